// ### ssec_top.sv
`timescale 1ns/1ps
`default_nettype none

module ssec_top
	import ssec_pkg::*;
#(
	parameter int UV_CYC = UV_DELAY_CYC
) (
	// clocking
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        ce,
	// comparator and pin inputs, asynchronous
	input  wire logic        por_ok,
	input  wire logic        release_above_rise,
	input  wire logic        release_above_fall,
	input  wire logic        vin_above_switch,
	input  wire logic        bias_above_switch,
	input  wire logic        vin_above_bias,
	input  wire logic        bias_above_forced,
	input  wire logic        enable_above_en_rise,
	input  wire logic        enable_above_uv_rise,
	input  wire logic        enable_above_uv_fall,
	input  wire logic        feedback_sense_above_sel,
	input  wire logic        readout_done,
	input  wire logic        readout_aux_en,
	// regulator and converter controls
	output logic             internal_bias_on,
	output logic             supply_chooser_bias,
	output logic             hysteresis_source_on,
	output logic             aux_regulator_en,
	output logic             gate_driver_prebias,
	output logic             gate_driver_full,
	output logic             converter_run,
	output logic             feedback_external,
	output logic             divider_range_select,
	output logic [16:0]      target_mv,
	// axi4-lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	localparam int UVW = $clog2(UV_CYC + 1);
	localparam logic [UVW-1:0] UV_LAST = UVW'(UV_CYC - 1);

	typedef struct packed {
		ssec_state_e   state;
		logic [UVW-1:0] uvc;
		logic          uv_trip;
		logic          sup_bias;
		logic          hyst;
		logic          fb_ext;
		logic          aux_en;
		logic          gd_pre;
		logic          gd_full;
		logic [3:0]    ctrl;
		logic [11:0]   tgt;
		logic [16:0]   mv;
		logic          aw_got;
		logic [7:0]    awaddr;
		logic          w_got;
		logic [31:0]   wdata;
		logic [3:0]    wstrb;
		logic          bvalid;
		logic [1:0]    bresp;
		logic          rvalid;
		logic [1:0]    rresp;
		logic [31:0]   rdata;
	} ssec_top_s;

	ssec_top_s r;
	ssec_top_s next_r;

	// synchronised comparator levels
	logic [12:0] sy;
	logic        s_por;
	logic        s_rel_rise;
	logic        s_rel_fall;
	logic        s_vin_sw;
	logic        s_bias_sw;
	logic        s_vin_gt;
	logic        s_bias_frc;
	logic        s_en_rise;
	logic        s_uv_rise;
	logic        s_uv_fall;
	logic        s_fb_sel;
	logic        s_rd_done;
	logic        s_rd_aux;

	// every comparator passes the synchroniser first
	ssec_sync #(
		.WIDTH (13)
	) u_sync (
		.clock (clock),
		.rst   (rst),
		.ce    (ce),
		.din   ({por_ok, release_above_rise, release_above_fall,
			vin_above_switch, bias_above_switch, vin_above_bias,
			bias_above_forced, enable_above_en_rise,
			enable_above_uv_rise, enable_above_uv_fall,
			feedback_sense_above_sel, readout_done, readout_aux_en}),
		.dout  (sy)
	);

	assign {s_por, s_rel_rise, s_rel_fall, s_vin_sw, s_bias_sw, s_vin_gt,
		s_bias_frc, s_en_rise, s_uv_rise, s_uv_fall, s_fb_sel,
		s_rd_done, s_rd_aux} = sy;

	// clamped target code, as software reads it back
	logic [11:0] tgt_clamped;
	always_comb begin
		if (r.ctrl[CTRL_DIV_SEL]) begin
			if (r.tgt < MIN_WIDE) begin
				tgt_clamped = MIN_WIDE;
			end else if (r.tgt > MAX_WIDE) begin
				tgt_clamped = MAX_WIDE;
			end else begin
				tgt_clamped = r.tgt;
			end
		end else begin
			if (r.tgt < MIN_NARROW) begin
				tgt_clamped = MIN_NARROW;
			end else if (r.tgt > MAX_NARROW) begin
				tgt_clamped = MAX_NARROW;
			end else begin
				tgt_clamped = r.tgt;
			end
		end
	end

	// handshake readies; nothing is taken while the clock enable is low
	assign s_axi_awready = ce & ~r.aw_got & ~r.bvalid;
	assign s_axi_wready  = ce & ~r.w_got & ~r.bvalid;
	assign s_axi_arready = ce & ~r.rvalid;

	logic        aw_fire;
	logic        w_fire;
	logic        wr_go;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	assign aw_fire = s_axi_awvalid & s_axi_awready;
	assign w_fire  = s_axi_wvalid & s_axi_wready;
	assign wr_go   = (r.aw_got | aw_fire) & (r.w_got | w_fire);
	assign wr_addr = r.aw_got ? r.awaddr : s_axi_awaddr;
	assign wr_data = r.w_got ? r.wdata : s_axi_wdata;
	assign wr_strb = r.w_got ? r.wstrb : s_axi_wstrb;

	logic uv_low;
	logic aux_sel;
	assign uv_low  = ~s_uv_fall;
	// while CTRL_AUX_OVR is set, the host's CTRL_AUX_EN bit overrides the resistor readout
	assign aux_sel = r.ctrl[CTRL_AUX_OVR] ? r.ctrl[CTRL_AUX_EN] : s_rd_aux;

	// next-state logic for power sequencing and register file
	always_comb begin
		next_r = r;

		// power state machine
		unique case (r.state)
			ST_SHUTDOWN: begin
				if (s_por && s_rel_rise) begin
					next_r.state = ST_STANDBY;
				end
			end
			ST_STANDBY: begin
				if (!s_por || !s_rel_fall) begin
					next_r.state = ST_SHUTDOWN;
				end else if (s_uv_rise && s_rd_done) begin
					next_r.state  = ST_ACTIVE;
					// feedback choice taken as soft-start begins
					next_r.fb_ext = ~s_fb_sel;
				end
			end
			ST_ACTIVE: begin
				if (!s_por || !s_rel_fall) begin
					next_r.state = ST_SHUTDOWN;
				end else if (uv_low && r.uvc == UV_LAST) begin
					next_r.state   = ST_STANDBY;
					next_r.uv_trip = 1'b1;
				end
			end
			default: begin
				next_r.state = ST_SHUTDOWN;
			end
		endcase

		// undervoltage debounce: any recovery restarts the count
		if (r.state == ST_ACTIVE && uv_low && r.uvc != UV_LAST) begin
			next_r.uvc = r.uvc + UVW'(1);
		end else begin
			next_r.uvc = '0;
		end
		if (r.state == ST_SHUTDOWN) begin
			next_r.uv_trip = 1'b0;
			next_r.fb_ext  = 1'b0;
		end else if (r.state == ST_STANDBY && s_uv_rise) begin
			next_r.uv_trip = 1'b0;
		end

		// supply chooser
		if (r.ctrl[CTRL_BIAS_PRI]) begin
			next_r.sup_bias = s_bias_frc;
		end else if (s_vin_sw && s_bias_sw) begin
			next_r.sup_bias = s_vin_gt;
		end else if (s_vin_sw != s_bias_sw) begin
			next_r.sup_bias = s_bias_sw;
		end else begin
			next_r.sup_bias = ~s_vin_gt;
		end

		// hysteresis source: on below enable, off above uv, else hold
		if (!s_en_rise) begin
			next_r.hyst = 1'b1;
		end else if (s_uv_rise) begin
			next_r.hyst = 1'b0;
		end

		// regulators follow the state of the next cycle
		next_r.aux_en  = (next_r.state != ST_SHUTDOWN) && s_rd_done
			&& aux_sel;
		next_r.gd_pre  = (next_r.state != ST_SHUTDOWN);
		next_r.gd_full = (next_r.state != ST_SHUTDOWN) && s_uv_rise;

		// target in millivolts for the reference path
		next_r.mv = 17'(r.tgt) * (r.ctrl[CTRL_DIV_SEL] ?
			17'(STEP_MV_WIDE) : 17'(STEP_MV_NARROW));

		// write channel capture, either order
		if (aw_fire) begin
			next_r.aw_got = 1'b1;
			next_r.awaddr = s_axi_awaddr;
		end
		if (w_fire) begin
			next_r.w_got = 1'b1;
			next_r.wdata = s_axi_wdata;
			next_r.wstrb = s_axi_wstrb;
		end
		if (wr_go) begin
			next_r.aw_got = 1'b0;
			next_r.w_got  = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp  = RESP_OKAY;
			unique case (wr_addr)
				ADDR_CTRL: begin
					if (wr_strb[0]) begin
						next_r.ctrl = wr_data[3:0];
					end
				end
				ADDR_TARGET: begin
					// stored raw; host rewrites after a range change
					if (wr_strb[0]) begin
						next_r.tgt[7:0] = wr_data[7:0];
					end
					if (wr_strb[1]) begin
						next_r.tgt[11:8] = wr_data[11:8];
					end
				end
				ADDR_STATUS: begin
					next_r.bresp = RESP_OKAY; // read-only, write ignored
				end
				default: begin
					next_r.bresp = RESP_SLVERR;
				end
			endcase
		end else if (r.bvalid && s_axi_bready) begin
			next_r.bvalid = 1'b0;
		end

		// read channel
		if (s_axi_arvalid && s_axi_arready) begin
			next_r.rvalid = 1'b1;
			next_r.rresp  = RESP_OKAY;
			next_r.rdata  = '0;
			unique case (s_axi_araddr)
				ADDR_CTRL: begin
					next_r.rdata[3:0] = r.ctrl;
				end
				ADDR_TARGET: begin
					next_r.rdata[11:0] = tgt_clamped;
				end
				ADDR_STATUS: begin
					next_r.rdata[ST_STATE_LO+:2] = r.state;
					next_r.rdata[ST_SUP_BIAS]    = r.sup_bias;
					next_r.rdata[ST_HYST]        = r.hyst;
					next_r.rdata[ST_FB_EXT]      = r.fb_ext;
					next_r.rdata[ST_GD_PRE]      = r.gd_pre;
					next_r.rdata[ST_GD_FULL]     = r.gd_full;
					next_r.rdata[ST_AUX_EN]      = r.aux_en;
					next_r.rdata[ST_RUN]         = (r.state == ST_ACTIVE);
					next_r.rdata[ST_UV_TRIP]     = r.uv_trip;
				end
				default: begin
					next_r.rresp = RESP_SLVERR;
				end
			endcase
		end else if (r.rvalid && s_axi_rready) begin
			next_r.rvalid = 1'b0;
		end
	end

	// one register for the whole block; clock enable freezes it
	always_ff @(posedge clock) begin
		if (rst) begin
			r       <= '0;
			r.state <= ST_SHUTDOWN;
			r.ctrl  <= CTRL_RESET;
			r.tgt   <= TARGET_RESET;
		end else if (ce) begin
			r <= next_r;
		end
	end

	// outputs from flip-flops; bias-on and run are decoded from the state register
	assign internal_bias_on     = (r.state != ST_SHUTDOWN);
	assign supply_chooser_bias  = r.sup_bias;
	assign hysteresis_source_on = r.hyst;
	assign aux_regulator_en     = r.aux_en;
	assign gate_driver_prebias  = r.gd_pre;
	assign gate_driver_full     = r.gd_full;
	assign converter_run        = (r.state == ST_ACTIVE);
	assign feedback_external    = r.fb_ext;
	assign divider_range_select = r.ctrl[CTRL_DIV_SEL];
	assign target_mv            = r.mv;
	assign s_axi_bvalid         = r.bvalid;
	assign s_axi_bresp          = r.bresp;
	assign s_axi_rvalid         = r.rvalid;
	assign s_axi_rresp          = r.rresp;
	assign s_axi_rdata          = r.rdata;

	// checks on the sequencing
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_standby_entry:
	assert property (ce && r.state == ST_SHUTDOWN && s_por && s_rel_rise
		|=> r.state == ST_STANDBY)
		else $error("standby not entered");

	a_shutdown_hold:
	assert property (ce && !s_rel_fall |=> r.state == ST_SHUTDOWN)
		else $error("shutdown not held");

	a_supply_lower:
	assert property (ce && !r.ctrl[CTRL_BIAS_PRI] && s_vin_sw && s_bias_sw
		|=> r.sup_bias == $past(s_vin_gt))
		else $error("lower supply not chosen");

	a_supply_single:
	assert property (ce && !r.ctrl[CTRL_BIAS_PRI] && s_vin_sw && !s_bias_sw
		|=> !r.sup_bias)
		else $error("low bias selected");

	a_supply_both_low:
	assert property (ce && !r.ctrl[CTRL_BIAS_PRI] && !s_vin_sw && !s_bias_sw
		|=> r.sup_bias == !$past(s_vin_gt))
		else $error("higher supply not chosen");

	a_bias_priority:
	assert property (ce && r.ctrl[CTRL_BIAS_PRI]
		|=> r.sup_bias == $past(s_bias_frc))
		else $error("bias priority ignored");

	a_uv_trip_time:
	assert property ($fell(converter_run) && s_rel_fall && s_por
		|-> $past(r.uvc) == UV_LAST)
		else $error("converter stopped before delay");

	a_hyst_source:
	assert property (ce && !s_en_rise |=> r.hyst)
		else $error("hysteresis source not on");

	a_aux_gated:
	assert property (aux_regulator_en
		|-> $past(s_rd_done) && internal_bias_on)
		else $error("aux enabled before readout");

	a_fb_latched:
	assert property (r.state == ST_ACTIVE ##1 r.state == ST_ACTIVE
		|-> $stable(r.fb_ext))
		else $error("feedback choice changed");

	a_target_clamp:
	assert property (
		tgt_clamped >= (r.ctrl[CTRL_DIV_SEL] ? MIN_WIDE : MIN_NARROW) &&
		tgt_clamped <= (r.ctrl[CTRL_DIV_SEL] ? MAX_WIDE : MAX_NARROW))
		else $error("readback out of range");
endmodule

`default_nettype wire

// ### ssec_pkg.sv
`timescale 1ns/1ps
`default_nettype none

package ssec_pkg;
	// register map, word aligned
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_TARGET = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;

	// control register fields
	localparam int CTRL_AUX_EN   = 0;
	localparam int CTRL_AUX_OVR  = 1;
	localparam int CTRL_BIAS_PRI = 2;
	localparam int CTRL_DIV_SEL  = 3;

	// status register fields
	localparam int ST_STATE_LO = 0;
	localparam int ST_SUP_BIAS = 2;
	localparam int ST_HYST     = 3;
	localparam int ST_FB_EXT   = 4;
	localparam int ST_GD_PRE   = 5;
	localparam int ST_GD_FULL  = 6;
	localparam int ST_AUX_EN   = 7;
	localparam int ST_RUN      = 8;
	localparam int ST_UV_TRIP  = 9;

	// reset values
	localparam logic [3:0]  CTRL_RESET   = 4'h0;
	localparam logic [11:0] TARGET_RESET = 12'h000;

	// output target scaling and clamp limits, in codes
	localparam int          TGT_W        = 12;
	localparam logic [4:0]  STEP_MV_NARROW = 5'h0A;
	localparam logic [4:0]  STEP_MV_WIDE   = 5'h14;
	localparam logic [11:0] MIN_NARROW   = 12'h064;
	localparam logic [11:0] MAX_NARROW   = 12'h960;
	localparam logic [11:0] MIN_WIDE     = 12'h0A5;
	localparam logic [11:0] MAX_WIDE     = 12'h960;

	// undervoltage shutdown delay
	localparam int CLK_PERIOD_NS = 50;
	localparam int UV_DELAY_NS   = 20000;
	localparam int UV_DELAY_CYC  =
		(UV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// power states
	typedef enum logic [1:0] {
		ST_SHUTDOWN = 2'b00,
		ST_STANDBY  = 2'b01,
		ST_ACTIVE   = 2'b10
	} ssec_state_e;
endpackage

// three-stage input synchroniser; a bit changes once stages two and three agree
module ssec_sync
	import ssec_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// clocking
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             ce,
	// data
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} ssec_sync_s;

	ssec_sync_s r;
	ssec_sync_s next_r;

	// first stage feeds only the second stage
	always_comb begin
		next_r    = r;
		next_r.s1 = din;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (r.s2[i] == r.s3[i]) begin
				next_r.q[i] = r.s3[i];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			r <= '0;
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign dout = r.q;
endmodule

`default_nettype wire

// ### ssec_host.sv
`timescale 1ns/1ps
`default_nettype none

// register host standing in for the port controller; one access at a time
module ssec_host (
	// clocking
	input  wire logic        clock,
	// write channels
	output logic [7:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic        bvalid,
	output logic             bready,
	// read channels
	output logic [7:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic        rvalid,
	output logic             rready
);
	// idle bus at time zero
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	// handshakes are judged at the falling edge, where readies have settled
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		logic b_ok;
		@(posedge clock);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'hF;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		b_ok = 1'b0;
		while (!b_ok) begin
			@(negedge clock);
			aw_ok = awvalid & awready;
			w_ok  = wvalid & wready;
			b_ok  = bvalid & bready;
			@(posedge clock);
			if (aw_ok)
				awvalid <= 1'b0;
			if (w_ok)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask

	// read; data is compared by the bench monitor
	task automatic rd(input logic [7:0] a);
		logic ar_ok;
		logic r_ok;
		@(posedge clock);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		r_ok = 1'b0;
		while (!r_ok) begin
			@(negedge clock);
			ar_ok = arvalid & arready;
			r_ok  = rvalid & rready;
			@(posedge clock);
			if (ar_ok)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask
endmodule

`default_nettype wire

// ### test_supply_select_enable_control.sv
`timescale 1ns/1ps
`default_nettype none

module test_supply_select_enable_control
	import ssec_pkg::*;
;
	logic        clock, rst, ce, por, rel_r, rel_f, vin_sw, bias_sw, vin_gt;
	logic        bias_f, en_r, uv_r, uv_f, fb, rd_done, rd_aux;
	logic        bias_on, sup_bias, hyst, aux_en, gd_pre, gd_full, run;
	logic        fb_ext, div_sel, prev, e;
	logic [16:0] tgt_mv;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [33:0] exp_q[$];
	logic [1:0]  exp_bq[$];
	logic [15:0] rnd;
	int          fails, check_count, cycles;

	ssec_top #(.UV_CYC(4)) u_dut (.clock(clock), .rst(rst), .ce(ce),
		.por_ok(por), .release_above_rise(rel_r),
		.release_above_fall(rel_f), .vin_above_switch(vin_sw),
		.bias_above_switch(bias_sw), .vin_above_bias(vin_gt),
		.bias_above_forced(bias_f), .enable_above_en_rise(en_r),
		.enable_above_uv_rise(uv_r), .enable_above_uv_fall(uv_f),
		.feedback_sense_above_sel(fb), .readout_done(rd_done),
		.readout_aux_en(rd_aux), .internal_bias_on(bias_on),
		.supply_chooser_bias(sup_bias), .hysteresis_source_on(hyst),
		.aux_regulator_en(aux_en), .gate_driver_prebias(gd_pre),
		.gate_driver_full(gd_full), .converter_run(run),
		.feedback_external(fb_ext), .divider_range_select(div_sel),
		.target_mv(tgt_mv), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	ssec_host u_host (.clock(clock), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rvalid(rvalid), .rready(rready));

	task automatic check(input logic [33:0] seen, input logic [33:0] exp,
			input string what);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask

	// note the expected answer, then issue the read
	task automatic rd_exp(input logic [7:0] a, input logic [1:0] r,
			input logic [31:0] d);
		exp_q.push_back({r, d});
		u_host.rd(a);
	endtask

	// note the expected write response, then issue the write
	task automatic wr_exp(input logic [7:0] a, input logic [31:0] d);
		exp_bq.push_back((a == ADDR_CTRL || a == ADDR_TARGET ||
			a == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR);
		u_host.wr(a, d);
	endtask

	// 16-bit lfsr for random target codes
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// range select, then target rewrite, as the host must after a change
	task automatic tgt(input logic dv, input logic [11:0] code);
		logic [11:0] lo;
		logic [11:0] ex;
		lo = dv ? 12'h0A5 : 12'h064; // 3.3 V in 20 mV, 1.0 V in 10 mV
		ex = code < lo ? lo : (code > 12'h960 ? 12'h960 : code);
		wr_exp(ADDR_CTRL, {28'h0000000, dv, 3'h3});
		wr_exp(ADDR_TARGET, {20'h00000, code});
		wt(2);
		check(div_sel, dv, "range");
		check(tgt_mv, {5'h00, code} * (dv ? 17'h00014 : 17'h0000A),
			"target_mv");
		rd_exp(ADDR_TARGET, RESP_OKAY, {20'h00000, ex});
	endtask

	// read data and write response watcher; answers settle before the falling edge
	always @(negedge clock) begin
		if (rvalid === 1'b1 && rready === 1'b1)
			check({rresp, rdata}, exp_q.pop_front(), "read");
		if (bvalid === 1'b1 && bready === 1'b1)
			check(bresp, exp_bq.pop_front(), "bresp");
	end

	// 20 MHz clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// hang guard, well above the expected run length
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			results();
		end
	end

	initial begin
		rst = 1'b1;
		ce  = 1'b1;
		{por, rel_r, rel_f, vin_sw, bias_sw, vin_gt, bias_f} = '0;
		{en_r, uv_r, uv_f, fb, rd_done, rd_aux} = '0;
		rnd = 16'h0048;
		wt(20);
		rst <= 1'b0;
		wt(8);
		check(bias_on, 1'b0, "bias_on");
		// standby entry; aux waits for the readout
		{por, rel_r, rel_f, rd_aux} <= 4'hF;
		wt(8);
		check(bias_on, 1'b1, "bias_on");
		check({gd_pre, gd_full}, 2'b10, "gate drv");
		check(hyst, 1'b1, "hyst");
		check(aux_en, 1'b0, "aux");
		rd_done <= 1'b1;
		wt(8);
		check(aux_en, 1'b1, "aux");
		wr_exp(ADDR_CTRL, 32'h00000002);
		wt(3);
		check(aux_en, 1'b0, "aux");
		$display("test standby done");
		// every supply combination, with and without bias priority
		prev = 1'b1;
		for (int i = 0; i < 32; i++) begin
			if (i[3:0] == 4'h0)
				wr_exp(ADDR_CTRL, {29'h0, i[4], 2'b11});
			{vin_sw, bias_sw, vin_gt, bias_f} <= i[3:0];
			wt(2);
			check(sup_bias, prev, "sync");
			wt(8);
			if (i[4])
				e = i[0];
			else if (i[3] & i[2])
				e = i[1];
			else if (i[3] ^ i[2])
				e = i[2];
			else
				e = ~i[1];
			check(sup_bias, e, "supply");
			prev = e;
		end
		$display("test supply done");
		// enable with the feedback pin low selects the external divider
		{en_r, uv_r, uv_f, fb} <= 4'hE;
		wt(10);
		check({gd_full, run, hyst, fb_ext}, 4'hD, "enable");
		fb <= 1'b1;
		wt(10);
		check(fb_ext, 1'b1, "fb latch");
		// short dip is ignored, a long one stops the converter
		uv_f <= 1'b0;
		wt(2);
		uv_f <= 1'b1;
		wt(10);
		check(run, 1'b1, "dip");
		{uv_r, uv_f} <= 2'b00;
		wt(3);
		check(run, 1'b1, "uv early");
		wt(12);
		check({run, hyst}, 2'b00, "uv trip");
		// standby, bias supply, fb external, prebias, aux on, trip flag
		rd_exp(ADDR_STATUS, RESP_OKAY, 32'h000002B5);
		{uv_r, uv_f} <= 2'b11;
		wt(10);
		check({run, fb_ext}, 2'b10, "resample");
		$display("test enable done");
		// clock enable low freezes every register and the synchroniser
		ce   <= 1'b0;
		en_r <= 1'b0;
		wt(10);
		check({run, hyst}, 2'b10, "freeze");
		ce <= 1'b1;
		wt(10);
		check(hyst, 1'b1, "thaw");
		en_r <= 1'b1;
		$display("test freeze done");
		// clamp edges in both ranges, then random codes
		tgt(1'b0, 12'h032);
		tgt(1'b0, 12'hBB8);
		tgt(1'b0, 12'h4D2);
		tgt(1'b1, 12'h064);
		tgt(1'b1, 12'h3E8);
		tgt(1'b1, 12'hFFF);
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			tgt(rnd[15], rnd[11:0]);
		end
		// unmapped address answers with an error and zero data
		rd_exp(8'h0C, RESP_SLVERR, 32'h00000000);
		// writes to the status word or a hole change nothing
		wr_exp(8'h0C, 32'h0000000F);
		wr_exp(ADDR_STATUS, 32'h0000000F);
		rd_exp(ADDR_CTRL, RESP_OKAY, {28'h0000000, rnd[15], 3'h3});
		$display("test target done");
		{rel_r, rel_f} <= 2'b00;
		wt(10);
		check({bias_on, aux_en, run}, 3'h0, "shutdown");
		$display("test shutdown done");
		wt(4);
		results();
	end
endmodule

`default_nettype wire
